/* hw/rmsel_input_selector.sv */
// Purpose: Routes remappable pins to interrupt and timer clock inputs.
// Assumes: Single clock; one-cycle read latency register port.
// Notes:   Peripheral inputs lag the pin by one registered cycle.
`timescale 1ns/1ps
`default_nettype none
module rmsel_input_selector
  import rmsel_pkg::*;
(
  input  wire logic                    CLOCK,
  input  wire logic                    RESET_N,
  input  wire logic [RMSEL_ADDR_W-1:0] ADDR,
  input  wire logic [RMSEL_DATA_W-1:0] WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output var  logic [RMSEL_DATA_W-1:0] RDATA,
  input  wire logic [RMSEL_PINS-1:0]   REMAPPABLE_PIN_N,
  output var  logic                    EXTERNAL_IRQ_ONE,
  output var  logic                    EXTERNAL_IRQ_TWO,
  output var  logic                    TIMER_ONE_EXT_CLOCK,
  output var  logic                    TIMER_TWO_EXT_CLOCK,
  output var  logic                    TIMER_THREE_EXT_CLOCK
);
  logic [7:0]              irq_one_pin_sel_reg, irq_one_pin_sel_next;
  logic [7:0]              irq_two_pin_sel_reg, irq_two_pin_sel_next;
  logic [7:0]              tmr_one_clk_pin_sel_reg, tmr_one_clk_pin_sel_next;
  logic [7:0]              tmr_two_clk_pin_sel_reg, tmr_two_clk_pin_sel_next;
  logic [7:0]              tmr_three_clk_pin_sel_reg, tmr_three_clk_pin_sel_next;
  logic [RMSEL_DATA_W-1:0] rdata_reg, rdata_next;
  logic [7:0]              sel_vec [RMSEL_NUM_SEL];
  logic [RMSEL_NUM_SEL-1:0] routed;

  // Writes land only in implemented byte lanes; other lanes are dropped
  always_comb begin
    irq_one_pin_sel_next       = irq_one_pin_sel_reg;
    irq_two_pin_sel_next       = irq_two_pin_sel_reg;
    tmr_one_clk_pin_sel_next   = tmr_one_clk_pin_sel_reg;
    tmr_two_clk_pin_sel_next   = tmr_two_clk_pin_sel_reg;
    tmr_three_clk_pin_sel_next = tmr_three_clk_pin_sel_reg;
    if (WR) begin
      case (ADDR)
        RMSEL_IRQ1_IDX: begin
          irq_one_pin_sel_next = WDATA[RMSEL_HI_LSB +: 8];
        end
        RMSEL_IRQ2_IDX: begin
          irq_two_pin_sel_next = WDATA[RMSEL_LO_LSB +: 8];
        end
        RMSEL_TMR1_IDX: begin
          tmr_one_clk_pin_sel_next = WDATA[RMSEL_HI_LSB +: 8];
        end
        RMSEL_TMR23_IDX: begin
          tmr_two_clk_pin_sel_next   = WDATA[RMSEL_LO_LSB +: 8];
          tmr_three_clk_pin_sel_next = WDATA[RMSEL_HI_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data built from stored fields; unused lanes and unmapped words read zero
  always_comb begin
    rdata_next = '0;
    if (RD) begin
      case (ADDR)
        RMSEL_IRQ1_IDX:  rdata_next = {irq_one_pin_sel_reg, 8'h00};
        RMSEL_IRQ2_IDX:  rdata_next = {8'h00, irq_two_pin_sel_reg};
        RMSEL_TMR1_IDX:  rdata_next = {tmr_one_clk_pin_sel_reg, 8'h00};
        RMSEL_TMR23_IDX: rdata_next = {tmr_three_clk_pin_sel_reg, tmr_two_clk_pin_sel_reg};
        default:         rdata_next = '0;
      endcase
    end
  end

  // All selectors clear so every input starts tied to ground
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_one_pin_sel_reg       <= RMSEL_SEL_RESET;
      irq_two_pin_sel_reg       <= RMSEL_SEL_RESET;
      tmr_one_clk_pin_sel_reg   <= RMSEL_SEL_RESET;
      tmr_two_clk_pin_sel_reg   <= RMSEL_SEL_RESET;
      tmr_three_clk_pin_sel_reg <= RMSEL_SEL_RESET;
      rdata_reg                 <= '0;
    end else begin
      irq_one_pin_sel_reg       <= irq_one_pin_sel_next;
      irq_two_pin_sel_reg       <= irq_two_pin_sel_next;
      tmr_one_clk_pin_sel_reg   <= tmr_one_clk_pin_sel_next;
      tmr_two_clk_pin_sel_reg   <= tmr_two_clk_pin_sel_next;
      tmr_three_clk_pin_sel_reg <= tmr_three_clk_pin_sel_next;
      rdata_reg                 <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;

  // Same encoding for every destination, so one slice serves all five
  assign sel_vec[0] = irq_one_pin_sel_reg;
  assign sel_vec[1] = irq_two_pin_sel_reg;
  assign sel_vec[2] = tmr_one_clk_pin_sel_reg;
  assign sel_vec[3] = tmr_two_clk_pin_sel_reg;
  assign sel_vec[4] = tmr_three_clk_pin_sel_reg;

  for (genvar g = 0; g < RMSEL_NUM_SEL; g++) begin : g_route
    rmsel_pin_mux u_mux (
      .clock   (CLOCK),
      .reset_n (RESET_N),
      .pins    (REMAPPABLE_PIN_N),
      .sel     (sel_vec[g]),
      .routed  (routed[g])
    );
  end

  assign EXTERNAL_IRQ_ONE      = routed[0];
  assign EXTERNAL_IRQ_TWO      = routed[1];
  assign TIMER_ONE_EXT_CLOCK   = routed[2];
  assign TIMER_TWO_EXT_CLOCK   = routed[3];
  assign TIMER_THREE_EXT_CLOCK = routed[4];

  // Checks against the selected pin one cycle back
  property p_irq1_route;
    @(posedge CLOCK) disable iff (!RESET_N)
      ($past(irq_one_pin_sel_reg) != 8'h00) |->
        EXTERNAL_IRQ_ONE == $past(REMAPPABLE_PIN_N[irq_one_pin_sel_reg]);
  endproperty
  a_irq1_route: assert property (p_irq1_route) else $error("irq one misrouted");

  property p_irq2_route;
    @(posedge CLOCK) disable iff (!RESET_N)
      ($past(irq_two_pin_sel_reg) != 8'h00) |->
        EXTERNAL_IRQ_TWO == $past(REMAPPABLE_PIN_N[irq_two_pin_sel_reg]);
  endproperty
  a_irq2_route: assert property (p_irq2_route) else $error("irq two misrouted");

  property p_irq1_write;
    @(posedge CLOCK) disable iff (!RESET_N)
      (WR && ADDR == 4'h0) |=> irq_one_pin_sel_reg == $past(WDATA[15:8]);
  endproperty
  a_irq1_write: assert property (p_irq1_write) else $error("irq one write lost");

  property p_pin_one;
    @(posedge CLOCK) disable iff (!RESET_N)
      (tmr_one_clk_pin_sel_reg == 8'h01) |=>
        TIMER_ONE_EXT_CLOCK == $past(REMAPPABLE_PIN_N[1]);
  endproperty
  a_pin_one: assert property (p_pin_one) else $error("pin one not routed");

  property p_ground;
    @(posedge CLOCK) disable iff (!RESET_N)
      (tmr_two_clk_pin_sel_reg == 8'h00) ##1 (tmr_two_clk_pin_sel_reg == 8'h00)
        |-> !TIMER_TWO_EXT_CLOCK;
  endproperty
  a_ground: assert property (p_ground) else $error("ground select not low");

  property p_lanes_zero;
    @(posedge CLOCK) disable iff (!RESET_N)
      (RD && ADDR == 4'h1) |=> RDATA[15:8] == 8'h00 && RDATA[7:0] == $past(irq_two_pin_sel_reg);
  endproperty
  a_lanes_zero: assert property (p_lanes_zero) else $error("unused lane not zero");

  property p_irq1_lo_zero;
    @(posedge CLOCK) disable iff (!RESET_N)
      (RD && ADDR == 4'h0) |=> RDATA[7:0] == 8'h00;
  endproperty
  a_irq1_lo_zero: assert property (p_irq1_lo_zero) else $error("low lane not zero");

  property p_tmr3_route;
    @(posedge CLOCK) disable iff (!RESET_N)
      ($past(tmr_three_clk_pin_sel_reg) != 8'h00) |->
        TIMER_THREE_EXT_CLOCK == $past(REMAPPABLE_PIN_N[tmr_three_clk_pin_sel_reg]);
  endproperty
  a_tmr3_route: assert property (p_tmr3_route) else $error("timer three misrouted");

  // Timer two shares the slice; a wrong index here would only show on this output
  property p_tmr2_route;
    @(posedge CLOCK) disable iff (!RESET_N)
      ($past(tmr_two_clk_pin_sel_reg) != 8'h00) |->
        TIMER_TWO_EXT_CLOCK == $past(REMAPPABLE_PIN_N[tmr_two_clk_pin_sel_reg]);
  endproperty
  a_tmr2_route: assert property (p_tmr2_route) else $error("timer two misrouted");

  // Each write lands in its own lane only
  property p_irq2_write;
    @(posedge CLOCK) disable iff (!RESET_N)
      (WR && ADDR == RMSEL_IRQ2_IDX) |=> irq_two_pin_sel_reg == $past(WDATA[7:0]);
  endproperty
  a_irq2_write: assert property (p_irq2_write) else $error("irq two write lost");

  property p_tmr1_write;
    @(posedge CLOCK) disable iff (!RESET_N)
      (WR && ADDR == RMSEL_TMR1_IDX) |=> tmr_one_clk_pin_sel_reg == $past(WDATA[15:8]);
  endproperty
  a_tmr1_write: assert property (p_tmr1_write) else $error("timer one write lost");

  property p_tmr23_write;
    @(posedge CLOCK) disable iff (!RESET_N)
      (WR && ADDR == RMSEL_TMR23_IDX) |=>
        {tmr_three_clk_pin_sel_reg, tmr_two_clk_pin_sel_reg} == $past(WDATA);
  endproperty
  a_tmr23_write: assert property (p_tmr23_write) else $error("timer word lost");

  // A write to an unmapped word must leave every selector alone
  property p_unmapped_write;
    @(posedge CLOCK) disable iff (!RESET_N)
      (WR && ADDR > RMSEL_TMR23_IDX) |=> $stable({irq_one_pin_sel_reg, irq_two_pin_sel_reg,
        tmr_one_clk_pin_sel_reg, tmr_two_clk_pin_sel_reg, tmr_three_clk_pin_sel_reg});
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("stray write landed");

  // Unmapped words and the unused timer one lane read back zero
  property p_unmapped_read;
    @(posedge CLOCK) disable iff (!RESET_N)
      (RD && ADDR > RMSEL_TMR23_IDX) |=> RDATA == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_tmr1_lo_zero;
    @(posedge CLOCK) disable iff (!RESET_N)
      (RD && ADDR == RMSEL_TMR1_IDX) |=> RDATA[7:0] == 8'h00;
  endproperty
  a_tmr1_lo_zero: assert property (p_tmr1_lo_zero) else $error("timer lane not zero");

  // Code zero ties the input low whatever the pins do
  property p_irq1_ground;
    @(posedge CLOCK) disable iff (!RESET_N)
      ($past(irq_one_pin_sel_reg) == RMSEL_SEL_GND) |-> !EXTERNAL_IRQ_ONE;
  endproperty
  a_irq1_ground: assert property (p_irq1_ground) else $error("irq one not grounded");

  property p_irq2_ground;
    @(posedge CLOCK) disable iff (!RESET_N)
      ($past(irq_two_pin_sel_reg) == RMSEL_SEL_GND) |-> !EXTERNAL_IRQ_TWO;
  endproperty
  a_irq2_ground: assert property (p_irq2_ground) else $error("irq two not grounded");

  property p_tmr3_ground;
    @(posedge CLOCK) disable iff (!RESET_N)
      ($past(tmr_three_clk_pin_sel_reg) == RMSEL_SEL_GND) |-> !TIMER_THREE_EXT_CLOCK;
  endproperty
  a_tmr3_ground: assert property (p_tmr3_ground) else $error("timer three not grounded");
endmodule // rmsel_input_selector
`default_nettype wire

/* common/rmsel_pkg.sv */
// Purpose: Constants for the remappable input selector.
// Assumes: 16-bit select words reached over a plain register port.
// Notes:   Word indices are local choices; no offsets are printed.
// Function
// - Upper byte of word 0 selects pin for external interrupt one.
// - Lower byte of word 1 selects pin for external interrupt two.
// - Nonzero selector value n routes remappable pin n to the input.
// - Selector value one routes remappable pin 1.
// - Selector value zero drives the input constant low.
// - Unimplemented byte lanes ignore writes and read back zero.
`default_nettype none
package rmsel_pkg;
  localparam int unsigned RMSEL_PINS      = 256;
  localparam int unsigned RMSEL_SEL_W     = 8;
  localparam int unsigned RMSEL_ADDR_W    = 4;
  localparam int unsigned RMSEL_DATA_W    = 16;
  localparam logic [3:0]  RMSEL_IRQ1_IDX  = 4'h0;
  localparam logic [3:0]  RMSEL_IRQ2_IDX  = 4'h1;
  localparam logic [3:0]  RMSEL_TMR1_IDX  = 4'h2;
  localparam logic [3:0]  RMSEL_TMR23_IDX = 4'h3;
  localparam logic [7:0]  RMSEL_SEL_RESET = 8'h00;
  localparam logic [7:0]  RMSEL_SEL_GND   = 8'h00;
  localparam int unsigned RMSEL_HI_LSB    = 8;
  localparam int unsigned RMSEL_LO_LSB    = 0;
  localparam int unsigned RMSEL_NUM_SEL   = 5;
endpackage
`default_nettype wire

/* hw/rmsel_pin_mux.sv */
// Purpose: One selector to pin routing slice.
// Assumes: Pin vector is synchronous to the clock.
// Notes:   Output is registered; code zero yields ground.
`timescale 1ns/1ps
`default_nettype none
module rmsel_pin_mux
  import rmsel_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic [RMSEL_PINS-1:0] pins,
  input  wire logic [7:0]            sel,
  output var  logic                  routed
);
  logic routed_reg;
  logic routed_next;

  // Pin index equals code; index 0 is ground, not a pin
  always_comb begin
    routed_next = pins[sel];
    if (sel == RMSEL_SEL_GND) begin
      routed_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      routed_reg <= 1'b0;
    end else begin
      routed_reg <= routed_next;
    end
  end

  assign routed = routed_reg;
endmodule // rmsel_pin_mux
`default_nettype wire

/* dv/test_remappable_input_selector.sv */
// Purpose: Self-checking bench for the remappable input selector.
// Assumes: Word map 0 irq1 hi, 1 irq2 lo, 2 timer1 hi, 3 timer2 lo and timer3 hi.
// Notes:   Outputs are registered, so pins are checked two edges after a change.
`timescale 1ns/1ps
`default_nettype none
module test_remappable_input_selector;
  import rmsel_pkg::*;
  logic                    CLOCK = 1'b0;
  logic                    RESET_N = 1'b0;
  logic [RMSEL_ADDR_W-1:0] ADDR = '0;
  logic [RMSEL_DATA_W-1:0] WDATA = '0;
  logic                    WR = 1'b0;
  logic                    RD = 1'b0;
  logic [RMSEL_DATA_W-1:0] RDATA;
  logic [RMSEL_PINS-1:0]   PINS = '0;
  logic [4:0]              outs;
  int                      n_errors = 0;
  int                      checks = 0;

  rmsel_input_selector u_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .REMAPPABLE_PIN_N(PINS),
    .EXTERNAL_IRQ_ONE(outs[0]), .EXTERNAL_IRQ_TWO(outs[1]), .TIMER_ONE_EXT_CLOCK(outs[2]),
    .TIMER_TWO_EXT_CLOCK(outs[3]), .TIMER_THREE_EXT_CLOCK(outs[4]));

  // Half period of the 4 ns clock
  always #2 CLOCK = ~CLOCK;

  // Compare and count; prints at once on a mismatch
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    WR <= 1'b1; ADDR <= a; WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge CLOCK);
    RD <= 1'b1; ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
  endtask

  // Reset values of every word and every output
  task t_reset;
    #1 chk({11'h000, outs}, 16'h0000);
    @(posedge CLOCK);
    RESET_N <= 1'b1;
    for (int i = 0; i < 5; i++) rd(i[3:0], 16'h0000);
    $display("test reset done");
  endtask

  // All ones written everywhere; unused lanes and unmapped words stay zero
  task t_lanes;
    for (int i = 0; i < 5; i++) wr(i[3:0], 16'hffff);
    rd(4'h0, 16'hff00);
    rd(4'h1, 16'h00ff);
    rd(4'h2, 16'hff00);
    rd(4'h3, 16'hffff);
    rd(4'h4, 16'h0000);
    $display("test lanes done");
  endtask

  // Route one code to one output and watch it follow the pin
  task t_route(input int k, input logic [7:0] code);
    logic [3:0]   a;
    logic [15:0]  d;
    logic [255:0] p;
    a = (k < 3) ? k[3:0] : 4'h3;
    d = (k == 1 || k == 3) ? {8'h00, code} : {code, 8'h00};
    p = (code == 8'h00) ? '1 : (256'h1 << code);
    wr(a, d);
    rd(a, d);
    @(posedge CLOCK);
    PINS <= p;
    repeat (2) @(posedge CLOCK);
    #1 chk({15'h0000, outs[k]}, {15'h0000, code != 8'h00});
    @(posedge CLOCK);
    PINS <= ~p;
    repeat (2) @(posedge CLOCK);
    #1 chk({15'h0000, outs[k]}, 16'h0000);
  endtask

  // Every output through pin 181, 180, 1 and ground
  task t_codes;
    for (int k = 0; k < 5; k++) begin
      t_route(k, 8'hb5);
      t_route(k, 8'hb4);
      t_route(k, 8'h01);
      t_route(k, 8'h00);
    end
    $display("test codes done");
  endtask

  // Reset in mid-run clears every selector, so all inputs fall back to ground
  task t_mid_reset;
    wr(RMSEL_IRQ1_IDX, 16'h0500);
    wr(RMSEL_TMR23_IDX, 16'h0003);
    @(posedge CLOCK);
    PINS <= '1;
    repeat (2) @(posedge CLOCK);
    #1 chk({11'h000, outs}, 16'h0009);
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    #1 chk({11'h000, outs}, 16'h0000);
    repeat (2) @(posedge CLOCK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    #1 chk({11'h000, outs}, 16'h0000);
    rd(RMSEL_IRQ1_IDX, 16'h0000);
    rd(RMSEL_TMR23_IDX, 16'h0000);
    @(posedge CLOCK);
    PINS <= '0;
    $display("test mid reset done");
  endtask

  // Verdict and end of run
  task results;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge CLOCK);
    t_reset;
    t_lanes;
    t_codes;
    t_mid_reset;
    results;
  end

  // Whole run needs a few hundred cycles; this bound cuts a hang short
  initial begin
    #100000;
    n_errors++;
    results;
  end
endmodule // test_remappable_input_selector
`default_nettype wire
